// >>> hdl/sac_pkg.sv
// Shared types and constants for the shared-arithmetic cell group
package sac_pkg;

  // ----------------------------------------------------------------
  // Group geometry
  // ----------------------------------------------------------------
  localparam int CELLS_PER_GROUP = 8;        // Cells in one group
  localparam int BITS_PER_CELL   = 2;        // Two dedicated adders per cell
  localparam int HALF_CELLS      = 4;        // Cells in one half of a group
  localparam int CHAIN_START_LO  = 0;        // First cell may start a chain
  localparam int CHAIN_START_HI  = 4;        // Fifth cell may start a chain
  localparam int LUT_INPUTS      = 4;        // Inputs per lookup table
  localparam int LUT_SIZE        = 16;       // Entries per lookup table
  localparam int CLEARS_PER_GROUP = 2;       // Distinct clears per group

  // ----------------------------------------------------------------
  // Truth tables of the three-input sum and carry on inputs a,b,c
  // ----------------------------------------------------------------
  localparam logic [15:0] LUT_SUM3   = 16'h9696;  // a^b^c
  localparam logic [15:0] LUT_CARRY3 = 16'hE8E8;  // majority(a,b,c)

  // ----------------------------------------------------------------
  // Register reset values
  // ----------------------------------------------------------------
  localparam logic REG_CLEAR_VAL  = 1'h0;
  localparam logic REG_PRESET_VAL = 1'h1;

  // ----------------------------------------------------------------
  // Group-wide register controls
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] aclr;        // Two distinct synchronous clears, active high
    logic       aload;       // Synchronous load / preset, active high
    logic [7:0] clr_sel;     // Per cell: which of the two clears it uses
    logic [7:0] shift_en;    // Per cell: register takes the chain input
  } sac_ctrl_s;

  // Chain configuration of the group
  typedef struct packed {
    logic       start_hi;    // Chain starts at the fifth cell
    logic       bypass_en;   // Chain runs through one half only
    logic       top_bypass;  // This column bypasses the top half
  } sac_chain_s;

endpackage

// >>> hdl/sac_cell.sv
// One logic cell in shared arithmetic mode: four LUTs, two adders, two registers
`timescale 1ns/1ps
`default_nettype none
module sac_cell
  import sac_pkg::*;
(
  // Clock and controls
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       dev_clr_n,
  input  wire logic       clr,
  input  wire logic       aload,
  input  wire logic       shift_en,
  // Operands per bit
  input  wire logic [1:0] op_a,
  input  wire logic [1:0] op_b,
  input  wire logic [1:0] op_c,
  // Chains
  input  wire logic       carry_in,
  input  wire logic       share_in,
  output logic            carry_out,
  output logic            share_out,
  // Register packing inputs and register chain
  input  wire logic       sixth_input_lower,
  input  wire logic       sixth_input_upper,
  input  wire logic       pack_en,
  input  wire logic       reg_chain_in,
  input  wire logic [1:0] aload_data,
  output logic [1:0]      sum_comb,
  output logic [1:0]      reg_q
);

  // ----------------------------------------------------------------
  // Lookup tables: two sum LUTs, two carry LUTs
  // ----------------------------------------------------------------
  logic [1:0] psum;
  logic [1:0] pcarry;
  logic [2:0] share;
  logic [2:0] carry;
  logic [1:0] d_in;
  logic [1:0] pack_d;

  assign share[0] = share_in;
  assign carry[0] = carry_in;
  assign pack_d   = {sixth_input_upper, sixth_input_lower};

  genvar i;
  generate
    for (i = 0; i < BITS_PER_CELL; i++) begin : g_bit
      logic [3:0] idx;
      assign idx       = {1'b0, op_c[i], op_b[i], op_a[i]};
      assign psum[i]   = LUT_SUM3[idx];
      assign pcarry[i] = LUT_CARRY3[idx];
      assign share[i+1] = pcarry[i];
      // Dedicated adder adds partial sum, shared carry in and carry chain
      assign sum_comb[i] = psum[i] ^ share[i] ^ carry[i];
      assign carry[i+1]  = (psum[i] & share[i]) | (psum[i] & carry[i]) | (share[i] & carry[i]);
      assign d_in[i] = shift_en ? ((i == 0) ? reg_chain_in : reg_q[0]) :
                       pack_en  ? pack_d[i] : sum_comb[i];
      // Register: device clear over clear over load over clock
      always_ff @(posedge clk) begin
        if (!dev_clr_n || !nrst) begin
          reg_q[i] <= REG_CLEAR_VAL;
        end else if (clr) begin
          reg_q[i] <= REG_CLEAR_VAL;
        end else if (aload) begin
          reg_q[i] <= aload_data[i];
        end else begin
          reg_q[i] <= d_in[i];
        end
      end
    end
  endgenerate

  assign share_out = share[2];
  assign carry_out = carry[2];

endmodule
`default_nettype wire

// >>> hdl/sac_group.sv
// Cell group of eight shared-arithmetic cells with chains and group controls
`timescale 1ns/1ps
`default_nettype none
module sac_group
  import sac_pkg::*;
#(
  parameter int  NCELL          = CELLS_PER_GROUP,
  parameter bit  DEV_CLR_ENABLE = 1'b1
)
(
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire logic                 DEVICE_WIDE_CLEAR_N,
  // Group controls and chain configuration
  input  wire sac_ctrl_s            CTRL,
  input  wire sac_chain_s           CHAIN_CFG,
  // Operands, two bits per cell
  input  wire logic [2*NCELL-1:0]   OP_A,
  input  wire logic [2*NCELL-1:0]   OP_B,
  input  wire logic [2*NCELL-1:0]   OP_C,
  input  wire logic [NCELL-1:0]     SIXTH_INPUT_LOWER,
  input  wire logic [NCELL-1:0]     SIXTH_INPUT_UPPER,
  input  wire logic [NCELL-1:0]     PACK_EN,
  input  wire logic [2*NCELL-1:0]   ALOAD_DATA,
  // Chains from the group below
  input  wire logic                 CARRY_IN,
  input  wire logic                 SHARE_IN,
  input  wire logic                 REG_CHAIN_IN,
  // Results
  output logic [2*NCELL-1:0]        SUM,
  output logic [2*NCELL-1:0]        REG_Q,
  output logic                      CARRY_OUT,
  output logic                      SHARE_OUT,
  output logic                      REG_CHAIN_OUT
);

  // ----------------------------------------------------------------
  // Chain entry selection
  // ----------------------------------------------------------------
  logic [NCELL:0]     carry_c;
  logic [NCELL:0]     share_c;
  logic [NCELL:0]     rchain;
  logic [NCELL-1:0]   c_out;
  logic [NCELL-1:0]   s_out;
  logic [2*NCELL-1:0] sum_w;
  logic               dev_clr_n_eff;
  logic [2:0]         dclr_sync;
  logic               bypass_top;
  logic               bypass_bot;
  logic               dclr_n_reg;
  logic               dclr_n_next;

  // Device clear pin passes three flops; a new level counts once the last two agree
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      dclr_sync  <= 3'h7;
      dclr_n_reg <= 1'b1;
    end else begin
      dclr_sync  <= {dclr_sync[1:0], DEVICE_WIDE_CLEAR_N};
      dclr_n_reg <= dclr_n_next;
    end
  end
  // A single-edge glitch on the pin never reaches the registers
  assign dclr_n_next   = (dclr_sync[2] == dclr_sync[1]) ? dclr_sync[2] : dclr_n_reg;
  assign dev_clr_n_eff = !DEV_CLR_ENABLE || dclr_n_reg;

  assign bypass_top = CHAIN_CFG.bypass_en && CHAIN_CFG.top_bypass;
  assign bypass_bot = CHAIN_CFG.bypass_en && !CHAIN_CFG.top_bypass;

  assign carry_c[0] = CARRY_IN;
  assign share_c[0] = SHARE_IN;
  assign rchain[0]  = REG_CHAIN_IN;

  // ----------------------------------------------------------------
  // Cells
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < NCELL; k++) begin : g_cell
      logic cin;
      logic sin;
      logic clr_k;
      logic skip;
      // Chain entry only at cell 0 or 4; start cuts the incoming chain
      if (k == CHAIN_START_HI) begin : g_hi
        assign cin = CHAIN_CFG.start_hi ? 1'b0 : carry_c[k];
        assign sin = CHAIN_CFG.start_hi ? 1'b0 : share_c[k];
      end else begin : g_other
        assign cin = carry_c[k];
        assign sin = share_c[k];
      end
      assign skip  = (k < HALF_CELLS) ? bypass_bot : bypass_top;
      assign clr_k = CTRL.aclr[CTRL.clr_sel[k]];

      sac_cell u_cell (
        .clk               (CLK),
        .nrst              (NRST),
        .dev_clr_n         (dev_clr_n_eff),
        .clr               (clr_k),
        .aload             (CTRL.aload),
        .shift_en          (CTRL.shift_en[k]),
        .op_a              (OP_A[2*k +: 2]),
        .op_b              (OP_B[2*k +: 2]),
        .op_c              (OP_C[2*k +: 2]),
        .carry_in          (cin),
        .share_in          (sin),
        .carry_out         (c_out[k]),
        .share_out         (s_out[k]),
        .sixth_input_lower (SIXTH_INPUT_LOWER[k]),
        .sixth_input_upper (SIXTH_INPUT_UPPER[k]),
        .pack_en           (PACK_EN[k]),
        .reg_chain_in      (rchain[k]),
        .aload_data        (ALOAD_DATA[2*k +: 2]),
        .sum_comb          (sum_w[2*k +: 2]),
        .reg_q             (REG_Q[2*k +: 2])
      );
      // Skipped cells pass the chain straight through
      assign carry_c[k+1] = skip ? cin : c_out[k];
      assign share_c[k+1] = skip ? sin : s_out[k];
      assign rchain[k+1]  = REG_Q[2*k+1];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered chain outputs to the next group and sum outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      SUM           <= '0;
      CARRY_OUT     <= 1'b0;
      SHARE_OUT     <= 1'b0;
      REG_CHAIN_OUT <= 1'b0;
    end else begin
      SUM           <= sum_w;
      CARRY_OUT     <= carry_c[NCELL];
      SHARE_OUT     <= share_c[NCELL];
      REG_CHAIN_OUT <= rchain[NCELL];
    end
  end

endmodule
`default_nettype wire

// >>> tb/sac_nbr_model.sv
// Model of the group below that feeds the chain inputs
`timescale 1ns/1ps
`default_nettype none
module sac_nbr_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Chain values out of the lower group
  input  wire logic [2:0] chain_d,
  output logic [2:0]      chain_q
);
  // Lower group drives its chain outputs from registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chain_q <= 3'h0;
    end else begin
      chain_q <= chain_d;
    end
  end
endmodule
`default_nettype wire

// >>> tb/sac_group_chk.sv
// Port assertions of the cell group
`timescale 1ns/1ps
`default_nettype none
module sac_group_chk
  import sac_pkg::*;
#(parameter int NCELL = CELLS_PER_GROUP)
(
  // Clock and reset
  input wire logic               CLK,
  input wire logic               NRST,
  input wire logic               DEVICE_WIDE_CLEAR_N,
  // Controls and data
  input wire sac_ctrl_s          CTRL,
  input wire sac_chain_s         CHAIN_CFG,
  input wire logic [2*NCELL-1:0] OP_A,
  input wire logic [2*NCELL-1:0] OP_B,
  input wire logic [2*NCELL-1:0] OP_C,
  input wire logic [NCELL-1:0]   SIXTH_INPUT_LOWER,
  input wire logic [NCELL-1:0]   SIXTH_INPUT_UPPER,
  input wire logic [NCELL-1:0]   PACK_EN,
  input wire logic [2*NCELL-1:0] ALOAD_DATA,
  input wire logic               CARRY_IN,
  input wire logic               SHARE_IN,
  // Results
  input wire logic [2*NCELL-1:0] SUM,
  input wire logic [2*NCELL-1:0] REG_Q
);
  // Packed data and the cells hit by their chosen clear
  logic [2*NCELL-1:0] pack_val;
  logic [2*NCELL-1:0] clr_mask;
  always_comb begin
    for (int k = 0; k < NCELL; k++) begin
      pack_val[2*k]    = SIXTH_INPUT_LOWER[k];
      pack_val[2*k+1]  = SIXTH_INPUT_UPPER[k];
      clr_mask[2*k+:2] = {2{CTRL.aclr[CTRL.clr_sel[k]]}};
    end
  end
  // No chain entry from below, no register control
  wire flat  = !CARRY_IN && !SHARE_IN && !CHAIN_CFG.bypass_en;
  wire quiet = CTRL.aclr == 2'h0 && !CTRL.aload && CTRL.shift_en == 8'h00;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence dev_idle; DEVICE_WIDE_CLEAR_N [*5]; endsequence
  sequence dev_low; !DEVICE_WIDE_CLEAR_N [*5]; endsequence
  sum_add_a: assert property ($past(NRST) && $past(flat && !CHAIN_CFG.start_hi)
    |-> SUM == $past(OP_A + OP_B + OP_C)) else $error("bad sum");
  split_start_a: assert property ($past(NRST) && $past(flat && CHAIN_CFG.start_hi)
    |-> SUM[15:8] == $past(OP_A[15:8] + OP_B[15:8] + OP_C[15:8])) else $error("bad split");
  clear_pick_a: assert property (|CTRL.aclr |=> (REG_Q & $past(clr_mask)) == '0)
    else $error("clear missed");
  clear_wins_a: assert property (CTRL.aload && &CTRL.aclr |=> REG_Q == '0)
    else $error("load beat clear");
  preset_load_a: assert property (dev_idle ##0 (CTRL.aload && CTRL.aclr == 2'h0)
    |=> REG_Q == $past(ALOAD_DATA)) else $error("load missed");
  dev_clear_a: assert property (dev_low ##0 CTRL.aload |=> REG_Q == '0)
    else $error("device clear missed");
  pack_a: assert property (dev_idle ##0 (quiet && &PACK_EN) |=> REG_Q == $past(pack_val))
    else $error("pack missed");
  reset_zero_a: assert property (disable iff (1'b0) !NRST |=> SUM == '0 && REG_Q == '0)
    else $error("reset missed");
endmodule
bind sac_group sac_group_chk #(.NCELL(NCELL)) i_sac_group_chk (.CLK, .NRST, .DEVICE_WIDE_CLEAR_N,
  .CTRL, .CHAIN_CFG, .OP_A, .OP_B, .OP_C, .SIXTH_INPUT_LOWER, .SIXTH_INPUT_UPPER, .PACK_EN,
  .ALOAD_DATA, .CARRY_IN, .SHARE_IN, .SUM, .REG_Q);
`default_nettype wire

// >>> tb/sac_group_tb_top.sv
// Self-checking bench of the cell group
`timescale 1ns/1ps
`default_nettype none
module sac_group_tb_top;
  import sac_pkg::*;
  logic        clk, nrst, dev_clr_n, reg_chain_out, carry_out, share_out;
  sac_ctrl_s   ctrl;
  sac_chain_s  cfg;
  logic [15:0] op_a, op_b, op_c, ld_data, sum, reg_q, r;
  logic [7:0]  six_lo, six_hi, pack_en;
  logic [2:0]  nbr_d, nbr_q;
  integer      seed = 68240;
  int          mismatches = 0;
  int          n_tests = 0;
  sac_nbr_model i_sac_nbr_model (.clk(clk), .nrst(nrst), .chain_d(nbr_d), .chain_q(nbr_q));
  sac_group i_sac_group (.CLK(clk), .NRST(nrst), .DEVICE_WIDE_CLEAR_N(dev_clr_n), .CTRL(ctrl),
    .CHAIN_CFG(cfg), .OP_A(op_a), .OP_B(op_b), .OP_C(op_c), .SIXTH_INPUT_LOWER(six_lo),
    .SIXTH_INPUT_UPPER(six_hi), .PACK_EN(pack_en), .ALOAD_DATA(ld_data), .CARRY_IN(nbr_q[0]),
    .SHARE_IN(nbr_q[1]), .REG_CHAIN_IN(nbr_q[2]), .SUM(sum), .REG_Q(reg_q), .CARRY_OUT(carry_out),
    .SHARE_OUT(share_out), .REG_CHAIN_OUT(reg_chain_out));
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string name, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Expected {chain pair total, sum}: three operands plus both chain inputs from below
  function automatic logic [17:0] exp_sum(input logic [15:0] a, b, c, input sac_chain_s g,
                                         input logic [1:0] cs);
    logic [9:0] lo;
    logic [9:0] hi;
    lo = 10'(a[7:0]) + 10'(b[7:0]) + 10'(c[7:0]) + 10'(cs[0]) + 10'(cs[1]);
    hi = 10'(a[15:8]) + 10'(b[15:8]) + 10'(c[15:8]);
    if (g.bypass_en && !g.top_bypass) begin
      hi = hi + 10'(cs[0]) + 10'(cs[1]);   // Lower half skipped: chain from below enters cell four
    end else if (!g.bypass_en && !g.start_hi) begin
      hi = hi + 10'(lo[9:8]);              // Unbroken chain across both halves
    end
    if (g.bypass_en && g.top_bypass) begin
      exp_sum = {lo[9:8], 8'h00, lo[7:0]}; // Upper half skipped: chain leaves after cell three
    end else begin
      exp_sum = {hi[9:8], hi[7:0], lo[7:0]};
    end
  endfunction
  function automatic logic [15:0] weave(input logic [7:0] lo, hi);
    for (int k = 0; k < 8; k++) begin
      weave[2*k+:2] = {hi[k], lo[k]};
    end
  endfunction
  // Back-to-back random operands, chain inputs and chain modes, two checks per edge
  task automatic run_sums(input int n, input logic keep);
    logic [15:0] a, b, c, m_now, m_prev;
    logic [17:0] e_now, e_prev;
    logic [1:0]  cs, cs_prev;
    logic        h, bp, tp;
    e_now   = '0;
    m_now   = '0;
    cs_prev = 2'h0;
    for (int i = 0; i <= n; i++) begin
      {a, b, c, h, bp, tp, cs} = 53'({$random(seed), $random(seed)});
      if (i == 1) begin
        {a, b, c, cs} = '1;
        {h, bp} = 2'h0;
      end
      @(posedge clk);
      {op_a, op_b, op_c} <= {a, b, c};
      cfg   <= '{h & !bp, bp, tp};
      nbr_d <= {keep, cs};
      e_prev  = e_now;
      m_prev  = m_now;
      // Chain inputs reach the group one edge late through the neighbour's registers
      e_now   = exp_sum(a, b, c, '{h & !bp, bp, tp}, cs_prev);
      m_now   = !bp ? 16'hFFFF : (tp ? 16'h00FF : 16'hFF00);
      cs_prev = cs;
      #1 if (i > 0) begin
        chk("SUM", sum & m_prev, e_prev[15:0] & m_prev);
        chk("CHAIN_OUT", {15'h0, carry_out} + {15'h0, share_out}, {14'h0, e_prev[17:16]});
      end
    end
  endtask
  // Controls set on one edge and left in place, registers checked after the next edge
  task automatic regs(input sac_ctrl_s c, input logic [15:0] ld, e);
    @(posedge clk);
    ctrl <= c;
    ld_data <= ld;
    @(posedge clk);
    #1 chk("REG_Q", reg_q, e);
  endtask
  // Main sequence
  initial begin
    {nrst, ctrl, cfg, op_a, op_b, op_c, ld_data, six_lo, six_hi, pack_en, nbr_d} = '0;
    dev_clr_n = 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk("SUM", sum, 16'h0000);
    chk("REG_Q", reg_q, 16'h0000);
    run_sums(40, 1'b0);
    regs('{2'h3, 1'b1, 8'h00, 8'h00}, 16'hFFFF, 16'h0000);
    regs('{2'h0, 1'b1, 8'h00, 8'h00}, 16'hFFFF, 16'hFFFF);
    regs('{2'h1, 1'b1, 8'hAA, 8'h00}, 16'hFFFF, 16'hCCCC);
    regs('{2'h2, 1'b1, 8'hAA, 8'h00}, 16'hFFFF, 16'h3333);
    r = 16'($random(seed));
    regs('{2'h0, 1'b1, 8'h00, 8'h00}, r, r);
    @(posedge clk);
    {six_lo, six_hi} <= 16'($random(seed));
    pack_en <= 8'hFF;
    #1 regs('{2'h0, 1'b0, 8'h00, 8'h00}, r, weave(six_lo, six_hi));
    regs('{2'h3, 1'b0, 8'h00, 8'h00}, r, 16'h0000);
    @(posedge clk);
    ctrl <= '{2'h0, 1'b0, 8'h00, 8'hFF};
    nbr_d <= 3'h4;
    run_sums(18, 1'b1);
    chk("REG_Q", reg_q, 16'hFFFF);
    chk("REG_CHAIN_OUT", {15'h0, reg_chain_out}, 16'h0001);
    @(posedge clk);
    ctrl <= '{2'h0, 1'b1, 8'h00, 8'h00};
    ld_data <= 16'hFFFF;
    dev_clr_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("REG_Q", reg_q, 16'h0000);
    complete_run();
  end
  // Watchdog
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
